// >>> gyro_pmu_pkg.sv
// Functional notes
// (R1) wake field: 01 pin one, 10 motion, 11 both
// (R2) sleep field: stillness, pin one idle, pin two
// (R3) wake beats sleep when both active
// (R4) pin conditions follow edge or level setting
// (R5) sleep target bit: suspend or fast start-up
// (R6) wake interrupt raised when enable bit set
// (R7) automatic transitions update gyro power state field
// (R8) gyro self-test bit four launches test
// (R9) accel amplitude bit: high one, low zero
// (R10) accel polarity bit: positive one, negative zero
// (R11) accel self-test field 01 enables all axes
// (R12) host waits 50 ms before reading results
// (R13) host sets accel config 0x2c first
// (R14) interface config loaded from nvm at boot
// (R15) watchdog enable bit acts in i2c mode
// (R16) watchdog period bit: 1 ms or 50 ms
// (R17) serial-only bit disables i2c in auto mode
// (R18) host writes zeros to reserved bits
// (R19) interface mode 00 is automatic detection
// (R20) watchdog resets stalled i2c slave, frees line
package gyro_pmu_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] addr_gyro_power_trigger = 8'h6c;
  localparam logic [7:0] addr_sensor_selftest_control = 8'h6d;
  localparam logic [7:0] addr_interface_nv_config = 8'h70;

  // reset values
  localparam logic [7:0] rst_gyro_power_trigger = 8'h00;
  localparam logic [7:0] rst_sensor_selftest_control = 8'h00;
  localparam logic [7:0] rst_interface_nv_config = 8'h00;

  // writable bits, reserved bits held at zero
  localparam logic [7:0] mask_gyro_power_trigger = 8'h7f;
  localparam logic [7:0] mask_sensor_selftest_control = 8'h1f;
  localparam logic [7:0] mask_interface_nv_config = 8'h07;

  ////////////////////////////////////////////////////////////////////////
  // field positions, power trigger register
  localparam int pos_wake_irq_en = 6;
  localparam int pos_sleep_target = 5;
  localparam int pos_wake_cond_hi = 4;
  localparam int pos_wake_cond_lo = 3;
  localparam int pos_sleep_cond_hi = 2;
  localparam int pos_sleep_cond_lo = 0;
  // wake field bits
  localparam int wake_bit_pin_one = 0;
  localparam int wake_bit_motion = 1;
  // sleep field bits
  localparam int sleep_bit_pin_two = 0;
  localparam int sleep_bit_pin_one_idle = 1;
  localparam int sleep_bit_still = 2;

  // self-test register
  localparam int pos_gyro_st_start = 4;
  localparam int pos_acc_st_amp = 3;
  localparam int pos_acc_st_sign = 2;
  localparam int pos_acc_st_en_hi = 1;
  localparam int pos_acc_st_en_lo = 0;
  localparam logic [1:0] acc_st_on = 2'h1;

  // interface config register
  localparam int pos_wdt_en = 2;
  localparam int pos_wdt_sel = 1;
  localparam int pos_serial_only = 0;
  localparam logic [1:0] if_mode_auto = 2'h0;
  localparam logic [1:0] if_mode_i2c_ois = 2'h1;

  ////////////////////////////////////////////////////////////////////////
  // gyro power state codes
  typedef enum logic [1:0] {
    gyro_suspend = 2'b00,
    gyro_normal = 2'b01,
    gyro_fast_startup = 2'b11
  } gyro_state_t;

  // watchdog timing
  localparam int clk_mhz = 100;
  localparam int wdt_short_ms = 1;
  localparam int wdt_long_ms = 50;
  localparam int wdt_short_cycles = wdt_short_ms * clk_mhz * 1000;
  localparam int wdt_long_cycles = wdt_long_ms * clk_mhz * 1000;
  localparam int wdt_width = 23;

endpackage

// >>> gyro_power_selftest_iface_regs.sv
`timescale 1ns/10ps
module gyro_power_selftest_iface_regs #(
  parameter int wdt_short_cycles = gyro_pmu_pkg::wdt_short_cycles,
  parameter int wdt_long_cycles = gyro_pmu_pkg::wdt_long_cycles
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic nvm_load,
  input wire logic [7:0] nvm_data,
  input wire logic irq_pin_one,
  input wire logic irq_pin_two,
  input wire logic irq_edge_mode,
  input wire logic any_motion,
  input wire logic no_motion,
  output logic [1:0] gyro_power_state,
  output logic gyro_state_update,
  output logic wake_irq,
  output logic gyro_selftest_start,
  output logic acc_selftest_enable,
  output logic acc_selftest_amp_high,
  output logic acc_selftest_positive,
  input wire logic [1:0] if_mode,
  input wire logic i2c_selected,
  input wire logic i2c_busy,
  input wire logic i2c_activity,
  output logic i2c_disable,
  output logic i2c_wdt_reset
);

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0] gyro_power_trigger;
    logic [7:0] sensor_selftest_control;
    logic [7:0] interface_nv_config;
    logic [7:0] rdata;
    logic [2:0] pin_one_sync;
    logic [2:0] pin_two_sync;
    logic pin_one;
    logic pin_two;
    gyro_pmu_pkg::gyro_state_t gyro_state;
    logic update;
    logic wake_irq;
    logic gyro_st_start;
    logic [gyro_pmu_pkg::wdt_width-1:0] wdt_count;
    logic wdt_reset;
  } regs_t;

  regs_t r;
  regs_t next_r;

  // three-stage sync, change accepted once stages two and three agree
  function automatic logic sync_level(input logic [2:0] s, input logic prev);
    sync_level = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  // condition seen by power logic: pulse on edge in edge mode, else level
  function automatic logic pin_cond(input logic now, input logic prev, input logic edge_mode,
                                    input logic want_high);
    logic lvl;
    logic lvl_prev;
    lvl = want_high ? now : ~now;
    lvl_prev = want_high ? prev : ~prev;
    pin_cond = edge_mode ? (lvl & ~lvl_prev) : lvl;
  endfunction

  logic pin_one_new;
  logic pin_two_new;
  logic [1:0] wake_field;
  logic [2:0] sleep_field;
  logic wake_hit;
  logic sleep_hit;
  logic pin_one_act;
  logic pin_one_idle;
  logic pin_two_act;
  logic wdt_active;
  logic [gyro_pmu_pkg::wdt_width-1:0] wdt_limit;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r = r;
    next_r.update = 1'b0;
    next_r.wake_irq = 1'b0;
    next_r.gyro_st_start = 1'b0;
    next_r.wdt_reset = 1'b0;

    // pin synchronisers
    next_r.pin_one_sync = {r.pin_one_sync[1:0], irq_pin_one};
    next_r.pin_two_sync = {r.pin_two_sync[1:0], irq_pin_two};
    pin_one_new = sync_level(r.pin_one_sync, r.pin_one);
    pin_two_new = sync_level(r.pin_two_sync, r.pin_two);
    next_r.pin_one = pin_one_new;
    next_r.pin_two = pin_two_new;

    pin_one_act = pin_cond(pin_one_new, r.pin_one, irq_edge_mode, 1'b1); // R4
    pin_one_idle = pin_cond(pin_one_new, r.pin_one, irq_edge_mode, 1'b0); // R4
    pin_two_act = pin_cond(pin_two_new, r.pin_two, irq_edge_mode, 1'b1); // R4

    // power transitions
    wake_field = r.gyro_power_trigger[gyro_pmu_pkg::pos_wake_cond_hi:gyro_pmu_pkg::pos_wake_cond_lo];
    sleep_field = r.gyro_power_trigger[gyro_pmu_pkg::pos_sleep_cond_hi:gyro_pmu_pkg::pos_sleep_cond_lo];
    wake_hit = (|wake_field) &
               (~wake_field[gyro_pmu_pkg::wake_bit_pin_one] | pin_one_act) &
               (~wake_field[gyro_pmu_pkg::wake_bit_motion] | any_motion); // R1
    sleep_hit = (sleep_field[gyro_pmu_pkg::sleep_bit_still] & no_motion) |
                (sleep_field[gyro_pmu_pkg::sleep_bit_pin_one_idle] & pin_one_idle) |
                (sleep_field[gyro_pmu_pkg::sleep_bit_pin_two] & pin_two_act); // R2
    if (wake_hit && r.gyro_state != gyro_pmu_pkg::gyro_normal) begin // R3
      next_r.gyro_state = gyro_pmu_pkg::gyro_normal; // R7
      next_r.update = 1'b1;
      next_r.wake_irq = r.gyro_power_trigger[gyro_pmu_pkg::pos_wake_irq_en]; // R6
    end else if (!wake_hit && sleep_hit && r.gyro_state == gyro_pmu_pkg::gyro_normal) begin // R3
      next_r.gyro_state = r.gyro_power_trigger[gyro_pmu_pkg::pos_sleep_target] ?
                          gyro_pmu_pkg::gyro_suspend : gyro_pmu_pkg::gyro_fast_startup; // R5 R7
      next_r.update = 1'b1;
    end

    // watchdog on the data line
    wdt_active = r.interface_nv_config[gyro_pmu_pkg::pos_wdt_en] & i2c_selected & ~i2c_disable; // R15
    wdt_limit = r.interface_nv_config[gyro_pmu_pkg::pos_wdt_sel] ?
                gyro_pmu_pkg::wdt_width'(wdt_long_cycles - 1) :
                gyro_pmu_pkg::wdt_width'(wdt_short_cycles - 1); // R16
    if (!wdt_active || !i2c_busy || i2c_activity) begin
      next_r.wdt_count = '0;
    end else if (r.wdt_count >= wdt_limit) begin
      next_r.wdt_count = '0;
      next_r.wdt_reset = 1'b1; // R20
    end else begin
      next_r.wdt_count = r.wdt_count + 1'b1;
    end

    // nvm load at boot
    if (nvm_load) begin
      next_r.interface_nv_config = nvm_data & gyro_pmu_pkg::mask_interface_nv_config; // R14
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        gyro_pmu_pkg::addr_gyro_power_trigger: begin
          next_r.gyro_power_trigger = reg_wdata & gyro_pmu_pkg::mask_gyro_power_trigger;
        end
        gyro_pmu_pkg::addr_sensor_selftest_control: begin
          next_r.sensor_selftest_control = reg_wdata & gyro_pmu_pkg::mask_sensor_selftest_control;
          next_r.gyro_st_start = reg_wdata[gyro_pmu_pkg::pos_gyro_st_start]; // R8
        end
        gyro_pmu_pkg::addr_interface_nv_config: begin
          next_r.interface_nv_config = reg_wdata & gyro_pmu_pkg::mask_interface_nv_config;
        end
        default: begin
        end
      endcase
    end

    // register reads
    if (reg_rd) begin
      case (reg_addr)
        gyro_pmu_pkg::addr_gyro_power_trigger: begin
          next_r.rdata = r.gyro_power_trigger;
        end
        gyro_pmu_pkg::addr_sensor_selftest_control: begin
          next_r.rdata = r.sensor_selftest_control;
        end
        gyro_pmu_pkg::addr_interface_nv_config: begin
          next_r.rdata = r.interface_nv_config;
        end
        default: begin
          next_r.rdata = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
      r.gyro_power_trigger <= gyro_pmu_pkg::rst_gyro_power_trigger;
      r.sensor_selftest_control <= gyro_pmu_pkg::rst_sensor_selftest_control;
      r.interface_nv_config <= gyro_pmu_pkg::rst_interface_nv_config;
      r.gyro_state <= gyro_pmu_pkg::gyro_normal;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign i2c_disable = (if_mode == gyro_pmu_pkg::if_mode_auto) &
                       r.interface_nv_config[gyro_pmu_pkg::pos_serial_only]; // R17 R19
  assign reg_rdata = r.rdata;
  assign gyro_power_state = r.gyro_state;
  assign gyro_state_update = r.update;
  assign wake_irq = r.wake_irq;
  assign gyro_selftest_start = r.gyro_st_start;
  assign acc_selftest_enable = r.sensor_selftest_control[gyro_pmu_pkg::pos_acc_st_en_hi:
                               gyro_pmu_pkg::pos_acc_st_en_lo] == gyro_pmu_pkg::acc_st_on; // R11
  assign acc_selftest_amp_high = r.sensor_selftest_control[gyro_pmu_pkg::pos_acc_st_amp]; // R9
  assign acc_selftest_positive = r.sensor_selftest_control[gyro_pmu_pkg::pos_acc_st_sign]; // R10
  assign i2c_wdt_reset = r.wdt_reset;

endmodule

// >>> gyro_power_selftest_iface_regs_assertions.sv
`timescale 1ns/10ps
module gyro_regs_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [1:0] if_mode,
  input wire logic [1:0] gyro_power_state,
  input wire logic gyro_state_update,
  input wire logic wake_irq,
  input wire logic gyro_selftest_start,
  input wire logic acc_selftest_enable,
  input wire logic acc_selftest_amp_high,
  input wire logic acc_selftest_positive,
  input wire logic i2c_disable,
  input wire logic i2c_wdt_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire st_wr = reg_wr && reg_addr == 8'h6d;
  wire st_go = st_wr && reg_wdata[4];
  wire nv_wr = reg_wr && reg_addr == 8'h70;
  ////////////////////////////////////////////////////////////////////////
  a_gyro_start: assert property (st_go |=> gyro_selftest_start)
    else $error("gyro start missing");
  a_start_cause: assert property (gyro_selftest_start |-> $past(st_go))
    else $error("stray gyro start");
  a_acc_enable: assert property (st_wr |=> acc_selftest_enable == ($past(reg_wdata[1:0]) == 2'h1))
    else $error("accel enable wrong");
  a_acc_fields: assert property (st_wr |=> acc_selftest_amp_high == $past(reg_wdata[3])
    && acc_selftest_positive == $past(reg_wdata[2]))
    else $error("accel amp or sign wrong");
  a_serial_only: assert property (nv_wr |=> i2c_disable == ($past(reg_wdata[0]) && if_mode == 2'h0))
    else $error("serial only wrong");
  a_update_moves: assert property (gyro_state_update |-> gyro_power_state != $past(gyro_power_state))
    else $error("update without change");
  a_change_flags: assert property ($past(rst_n) && gyro_power_state != $past(gyro_power_state)
    |-> gyro_state_update)
    else $error("change without update");
  a_wake_normal: assert property (wake_irq |-> gyro_state_update && gyro_power_state == 2'b01)
    else $error("wake irq without wake");
  a_wdt_pulse: assert property (i2c_wdt_reset |=> !i2c_wdt_reset)
    else $error("watchdog pulse too long");
endmodule
bind gyro_power_selftest_iface_regs gyro_regs_checker u_chk (.*);

// >>> gyro_power_selftest_iface_regs_bench.sv
`timescale 1ns/10ps
module gyro_power_selftest_iface_regs_bench;
  logic core_clk, rst_n, nvm_load, irq_pin_one, irq_pin_two, irq_edge_mode, any_motion, no_motion;
  logic i2c_selected, i2c_busy, i2c_activity;
  logic [1:0] if_mode;
  logic [7:0] nvm_data, q;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic reg_wr, reg_rd, gyro_state_update, wake_irq, gyro_selftest_start, acc_selftest_enable;
  wire logic acc_selftest_amp_high, acc_selftest_positive, i2c_disable, i2c_wdt_reset;
  wire logic [1:0] gyro_power_state;
  int error_cnt = 0;
  int n_checks = 0;
  int irq_n = 0;
  int upd_n = 0;
  gyro_power_selftest_iface_regs #(.wdt_short_cycles(20), .wdt_long_cycles(50)) u_dut (.*);
  host_model u_host (.*);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (wake_irq === 1'b1) irq_n <= irq_n + 1;
  always @(posedge core_clk) if (gyro_state_update === 1'b1) upd_n <= upd_n + 1;
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_state(input logic [1:0] e);
    int i;
    for (i = 0; i < 12 && gyro_power_state !== e; i++) @(posedge core_clk);
    cmp({6'h00, gyro_power_state}, {6'h00, e});
    if (i == 12) print_verdict();
  endtask
  task automatic wdt_gap(input int lo, input int hi);
    int i;
    for (i = 0; i < 90 && i2c_wdt_reset !== 1'b1; i++) @(posedge core_clk);
    cmp({7'h00, i >= lo && i <= hi}, 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    @(posedge core_clk);
    nvm_data <= 8'h05;
    nvm_load <= 1'b1;
    @(posedge core_clk);
    nvm_load <= 1'b0;
    u_host.rd(8'h70, q);
    cmp(q, 8'h05);
    u_host.rd(8'h6c, q);
    cmp(q, 8'h00);
    u_host.wr(8'h40, 8'h2c);
    u_host.rd(8'h40, q);
    cmp(q, 8'h00);
  endtask
  task automatic t_selftest();
    u_host.wr(8'h6d, 8'h1d);
    #1 cmp({7'h00, gyro_selftest_start}, 8'h01);
    cmp({4'h0, acc_selftest_amp_high, acc_selftest_positive, 1'b0, acc_selftest_enable}, 8'h0d);
    u_host.wr(8'h6d, 8'h02);
    #1 cmp({4'h0, acc_selftest_amp_high, acc_selftest_positive, gyro_selftest_start, acc_selftest_enable}, 8'h00);
    u_host.rd(8'h6d, q);
    cmp(q, 8'h02);
  endtask
  task automatic t_power();
    u_host.wr(8'h6c, 8'h74);
    no_motion <= 1'b1;
    wait_state(2'b00);
    any_motion <= 1'b1;
    wait_state(2'b01);
    repeat (4) @(posedge core_clk);
    cmp({6'h00, gyro_power_state}, 8'h01);
    cmp(irq_n[7:0], 8'h01);
    no_motion <= 1'b0;
    any_motion <= 1'b0;
    u_host.wr(8'h6c, 8'h0a);
    wait_state(2'b11);
    irq_pin_one <= 1'b1;
    wait_state(2'b01);
    cmp(irq_n[7:0], 8'h01);
    u_host.wr(8'h6c, 8'h19);
    irq_pin_two <= 1'b1;
    wait_state(2'b11);
    repeat (6) @(posedge core_clk);
    cmp({6'h00, gyro_power_state}, 8'h03);
    irq_pin_two <= 1'b0;
    any_motion <= 1'b1;
    wait_state(2'b01);
    irq_edge_mode <= 1'b1;
    u_host.wr(8'h6c, 8'h0a);
    repeat (6) @(posedge core_clk);
    cmp({6'h00, gyro_power_state}, 8'h01);
    irq_pin_one <= 1'b0;
    wait_state(2'b11);
    irq_pin_one <= 1'b1;
    wait_state(2'b01);
    repeat (2) @(posedge core_clk);
    cmp(upd_n[7:0], 8'h08);
    cmp(irq_n[7:0], 8'h01);
  endtask
  task automatic t_iface();
    u_host.wr(8'h70, 8'h01);
    #1 cmp({7'h00, i2c_disable}, 8'h01);
    @(posedge core_clk);
    if_mode <= 2'h1;
    #1 cmp({7'h00, i2c_disable}, 8'h00);
    i2c_selected <= 1'b1;
    i2c_busy <= 1'b1;
    u_host.wr(8'h70, 8'h04);
    wdt_gap(17, 23);
    u_host.wr(8'h70, 8'h06);
    wdt_gap(44, 53);
    u_host.wr(8'h70, 8'h04);
    i2c_activity <= 1'b1;
    wdt_gap(90, 90);
    i2c_activity <= 1'b0;
    u_host.wr(8'h70, 8'h00);
    wdt_gap(90, 90);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {nvm_load, irq_pin_one, irq_pin_two, irq_edge_mode, any_motion, no_motion} = 6'h00;
    {i2c_selected, i2c_busy, i2c_activity} = 3'h0;
    if_mode = 2'h0;
    nvm_data = 8'h00;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_selftest();
    t_power();
    t_iface();
    print_verdict();
  end
endmodule

// >>> host_model.sv
`timescale 1ns/10ps
module host_model (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // data scrambled once the strobe is gone
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    #1 d = reg_rdata;
  endtask
endmodule
